/* File: hdl/flash_serial_pin_frontend.sv */
// Purpose: pin-level serial front end of a serial NOR flash
// Assumes: serial clock sampled by clk_i (125 MHz), well below clk_i/4
// Notes:   modes 0 and 3 only; lane mode chosen by the command core
`include "flash_pins_defines.svh"

module flash_serial_pin_frontend (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      sclk_i,
  input  wire logic                      select_n_i,
  input  wire logic [`LANE_W-1:0]        lane_i,
  output logic      [`LANE_W-1:0]        lane_o,
  output logic      [`LANE_W-1:0]        lane_oe_o,
  input  wire flash_pins_pkg::lane_mode_t lane_mode_i,
  input  wire logic                      quad_enable_bit_i,
  input  wire logic                      lane3_function_select_i,
  input  wire logic                      tx_dir_i,
  input  wire logic [7:0]                tx_byte_i,
  output logic                           tx_ready_o,
  output logic [7:0]                     rx_byte_o,
  output logic                           rx_valid_o,
  output logic                           rx_first_o,
  output logic                           selected_o,
  output logic                           standby_o,
  output logic                           write_protect_n_o,
  output logic                           pin_reset_o
);
  logic                     sclk_s;
  logic                     sel_n_s;
  logic [`LANE_W-1:0]       lane_s;
  logic                     sclk_d;
  logic                     sel_n_d;
  logic                     armed;
  logic                     first_pending;
  logic [`BIT_CNT_W-1:0]    bit_cnt;
  logic [7:0]               rx_sh;
  logic [7:0]               tx_sh;
  logic [`LANE_W-1:0]       drive;
  logic                     out_en;
  logic                     next_sclk_d;
  logic                     next_sel_n_d;
  logic                     next_armed;
  logic                     next_first_pending;
  logic [`BIT_CNT_W-1:0]    next_bit_cnt;
  logic [7:0]               next_rx_sh;
  logic [7:0]               next_tx_sh;
  logic [`LANE_W-1:0]       next_drive;
  logic                     next_out_en;
  logic [7:0]               next_rx_byte;
  logic                     next_rx_valid;
  logic                     next_rx_first;
  logic                     next_tx_ready;
  logic                     rise;
  logic                     fall;
  logic                     active;
  logic                     paused;
  logic                     pause_fn;
  logic [`BIT_CNT_W-1:0]    step;
  logic [7:0]               rx_shift;

  // pins cross into clk_i through two flops before any logic
  // select resets as if low: a select held low through reset is no fall
  pin_sync #(.WIDTH(2 + `LANE_W)) u_sync (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .async_i     ({sclk_i, select_n_i, lane_i}),
    .reset_val_i ({1'h0, 1'h0, 4'hF}),
    .sync_o      ({sclk_s, sel_n_s, lane_s})
  );

  // lane 3 role; quad enable removes pin functions entirely
  always_comb begin
    pause_fn          = !quad_enable_bit_i && !lane3_function_select_i;
    paused            = pause_fn && !lane_s[3] && !sel_n_s;
    pin_reset_o       = !quad_enable_bit_i && lane3_function_select_i && !lane_s[3];
    write_protect_n_o = quad_enable_bit_i ? 1'h1 : lane_s[2];
  end

  // edge detection works for either idle level, so modes 0 and 3 both fit
  always_comb begin
    rise   = sclk_s && !sclk_d;
    fall   = !sclk_s && sclk_d;
    active = armed && !sel_n_s && !paused;
    case (lane_mode_i)
      flash_pins_pkg::lane_dual: begin
        step     = `BITS_DUAL;
        rx_shift = {rx_sh[5:0], lane_s[1:0]};
      end
      flash_pins_pkg::lane_quad: begin
        step     = `BITS_QUAD;
        rx_shift = {rx_sh[3:0], lane_s};
      end
      default: begin
        step     = `BITS_SINGLE;
        rx_shift = {rx_sh[6:0], lane_s[0]};
      end
    endcase
  end

  // framing, shifting and output timing
  always_comb begin
    next_sclk_d        = sclk_s;
    next_sel_n_d       = sel_n_s;
    next_armed         = armed;
    next_first_pending = first_pending;
    next_bit_cnt       = bit_cnt;
    next_rx_sh         = rx_sh;
    next_tx_sh         = tx_sh;
    next_drive         = drive;
    next_out_en        = out_en;
    next_rx_byte       = rx_byte_o;
    next_rx_valid      = 1'h0;
    next_rx_first      = rx_first_o;
    next_tx_ready      = 1'h0;
    if (!rst_n_i) begin
      next_sclk_d        = 1'h0;
      next_sel_n_d       = 1'h0;
      next_armed         = 1'h0;
      next_first_pending = 1'h0;
      next_bit_cnt       = 3'h0;
      next_rx_sh         = 8'h00;
      next_tx_sh         = 8'h00;
      next_drive         = 4'h0;
      next_out_en        = 1'h0;
      next_rx_byte       = 8'h00;
      next_rx_first      = 1'h0;
    end else if (sel_n_s || pin_reset_o) begin
      next_bit_cnt = 3'h0;
      next_out_en  = 1'h0;
      next_armed   = armed && !pin_reset_o;
      if (!sel_n_d && sel_n_s) begin
        next_first_pending = 1'h0;
      end
    end else begin
      if (sel_n_d && !sel_n_s) begin
        next_armed         = 1'h1;
        next_first_pending = 1'h1;
        next_tx_ready      = 1'h1;
      end
      if (active && rise && !tx_dir_i) begin
        next_rx_sh   = rx_shift;
        next_bit_cnt = bit_cnt + step;
        if ((bit_cnt + step) == 3'h0) begin
          next_rx_byte       = rx_shift;
          next_rx_valid      = 1'h1;
          next_rx_first      = first_pending;
          next_first_pending = 1'h0;
        end
      end
      if (active && fall && tx_dir_i) begin
        next_out_en = 1'h1;
        if (bit_cnt == 3'h0) begin
          next_tx_sh    = tx_byte_i;
          next_tx_ready = 1'h1;
        end else begin
          next_tx_sh = tx_sh << step;
        end
        next_bit_cnt = bit_cnt + step;
      end
      if (!tx_dir_i) begin
        next_out_en = 1'h0;
      end
    end
    // msb of the current group goes on the lanes in use
    case (lane_mode_i)
      flash_pins_pkg::lane_dual: next_drive = {2'h0, next_tx_sh[7:6]};
      flash_pins_pkg::lane_quad: next_drive = next_tx_sh[7:4];
      default:                   next_drive = {2'h0, next_tx_sh[7], 1'h0};
    endcase
  end

  always_ff @(posedge clk_i) begin
    sclk_d        <= next_sclk_d;
    sel_n_d       <= next_sel_n_d;
    armed         <= next_armed;
    first_pending <= next_first_pending;
    bit_cnt       <= next_bit_cnt;
    rx_sh         <= next_rx_sh;
    tx_sh         <= next_tx_sh;
    drive         <= next_drive;
    out_en        <= next_out_en;
    rx_byte_o     <= next_rx_byte;
    rx_valid_o    <= next_rx_valid;
    rx_first_o    <= next_rx_first;
    tx_ready_o    <= next_tx_ready;
  end

  // enables: released while deselected or paused; lane use by mode
  always_comb begin
    lane_o    = drive;
    lane_oe_o = 4'h0;
    if (out_en && !sel_n_s && !paused) begin
      case (lane_mode_i)
        flash_pins_pkg::lane_dual: lane_oe_o = 4'h3;
        flash_pins_pkg::lane_quad: lane_oe_o = 4'hF;
        default:                   lane_oe_o = 4'h2;
      endcase
    end
    selected_o = !sel_n_s && armed;
    standby_o  = sel_n_s;
  end

  property p_release_deselect;
    @(posedge clk_i) disable iff (!rst_n_i) sel_n_s |-> lane_oe_o == 4'h0;
  endproperty
  a_release_deselect: assert property (p_release_deselect) else $error("lanes driven while deselected");

  property p_no_rx_idle;
    @(posedge clk_i) disable iff (!rst_n_i) $past(sel_n_s) |-> !rx_valid_o;
  endproperty
  a_no_rx_idle: assert property (p_no_rx_idle) else $error("byte received while deselected");

  property p_armed_after_fall;
    @(posedge clk_i) disable iff (!rst_n_i) (sel_n_d && !sel_n_s && !pin_reset_o) |=> armed;
  endproperty
  a_armed_after_fall: assert property (p_armed_after_fall) else $error("select fall did not arm");

  property p_no_rx_unarmed;
    @(posedge clk_i) disable iff (!rst_n_i) !$past(armed) |-> !rx_valid_o;
  endproperty
  a_no_rx_unarmed: assert property (p_no_rx_unarmed) else $error("byte before first select fall");

  property p_single_lane1;
    @(posedge clk_i) disable iff (!rst_n_i) (lane_mode_i == flash_pins_pkg::lane_single) |-> !lane_oe_o[0];
  endproperty
  a_single_lane1: assert property (p_single_lane1) else $error("lane 0 driven in single mode");

  property p_pause_release;
    @(posedge clk_i) disable iff (!rst_n_i) paused |-> !lane_oe_o[1];
  endproperty
  a_pause_release: assert property (p_pause_release) else $error("lane 1 driven while paused");

  property p_qe_wp;
    @(posedge clk_i) disable iff (!rst_n_i) quad_enable_bit_i |-> (write_protect_n_o && !pin_reset_o);
  endproperty
  a_qe_wp: assert property (p_qe_wp) else $error("pin function active with quad enable");

  property p_frame_end;
    @(posedge clk_i) disable iff (!rst_n_i) (!sel_n_d && sel_n_s) |=> (bit_cnt == 3'h0 && !first_pending);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("framing not cleared at select rise");
endmodule : flash_serial_pin_frontend

/* File: hdl/flash_pins_defines.svh */
// Purpose: named constants for the serial flash pin front end
// Assumes: 125 MHz system clock, sampled serial clock
// Notes:   definitions only
`ifndef FLASH_PINS_DEFINES_SVH
`define FLASH_PINS_DEFINES_SVH
`define LANE_W        4
`define BIT_CNT_W     3
`define BITS_SINGLE   3'h1
`define BITS_DUAL     3'h2
`define BITS_QUAD     3'h4
`define BYTE_LAST     3'h7
`define SYNC_STAGES   2
`endif

/* File: hdl/flash_pins_pkg.sv */
// Purpose: types for the serial flash pin front end
// Assumes: nothing
// Notes:   constants live in flash_pins_defines.svh
package flash_pins_pkg;
  typedef enum logic [1:0] {
    lane_single,
    lane_dual,
    lane_quad
  } lane_mode_t;
endpackage : flash_pins_pkg

/* File: hdl/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   first stage is read only by the second stage
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] next_stage;

  // reset value is a tied constant at every instance
  always_comb begin
    next_meta  = rst_n_i ? async_i : reset_val_i;
    next_stage = rst_n_i ? meta    : reset_val_i;
  end

  always_ff @(posedge clk_i) begin
    meta  <= next_meta;
    stage <= next_stage;
  end

  assign sync_o = stage;
endmodule : pin_sync

/* File: test/host_model.sv */
// Purpose: host controller model for the serial flash pins
// Assumes: 8 ns bench clock; pins change at its falling edge
// Notes:   serial clock stands still between frames
module host_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] wire_i,
  output logic            sclk_o,
  output logic            select_n_o,
  output logic [3:0]      d_o,
  output logic [3:0]      oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_hi;
  // protect and pause pins rest high; select starts high
  initial begin
    {idle_hi, sclk_o, select_n_o} = 3'h1;
    {d_o, oe_o} = 8'hFC;
  end
  // release hands lanes 2 and 3 back to their pin roles
  task automatic sel(input logic v);
    @(negedge clk_i);
    {sclk_o, select_n_o} = {idle_hi, v};
    if (v) {d_o, oe_o} = 8'hFC;
    repeat (6) @(negedge clk_i);
  endtask : sel
  task automatic pins(input logic p, input logic w);
    @(negedge clk_i);
    d_o[3:2] = {p, w};
    repeat (8) @(negedge clk_i);
  endtask : pins
  // w lanes, n groups, msb first: set at the fall, sampled just before the rise
  task automatic xfer(input logic [7:0] b, input int w, input int n, input logic wr, output logic [7:0] r);
    logic [3:0] m;
    logic [3:0] s;
    m = 4'((1 << w) - 1);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      oe_o = w == 4 ? {4{wr}} : {2'h3, m[1:0] & {2{wr}}};
      d_o = (d_o & ~m) | (4'(b >> (8 - w * (i + 1))) & m);
      sclk_o = 1'b0;
      repeat (10) @(negedge clk_i);
      s = w == 1 ? {3'h0, wire_i[1]} : wire_i & m;
      r = (r << w) | 8'(s);
      sclk_o = 1'b1;
      repeat (10) @(negedge clk_i);
      sclk_o = idle_hi;
    end
  endtask : xfer
endmodule : host_model

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the serial flash pin front end
// Assumes: host model drives the pins; serial clock period 168 ns
// Notes:   undriven lanes toggle each cycle so stale data never matches
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0, flip = 1'b0, rst_n_i, sclk, sel_n, qe, fsel, tx_dir, tx_ready_o;
  logic [3:0] h_d, h_oe, lane_i, lane_o, lane_oe_o;
  logic [7:0] tx_byte, rx_byte_o, last_b;
  logic       rx_valid_o, rx_first_o, selected_o, standby_o, wp_n_o, pin_reset_o, last_f;
  int         mismatches = 0, tests_run = 0, rx_cnt = 0, tx_cnt = 0, cycles = 0;
  flash_pins_pkg::lane_mode_t mode;
  always #4 clk_i = ~clk_i;
  // wire level from host and device drive
  assign lane_i = (h_oe & h_d) | (~h_oe & lane_oe_o & lane_o) | (~h_oe & ~lane_oe_o & {4{flip}});
  host_model host_model_i (.clk_i(clk_i), .wire_i(lane_i), .sclk_o(sclk), .select_n_o(sel_n), .d_o(h_d), .oe_o(h_oe));
  flash_serial_pin_frontend flash_serial_pin_frontend_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .select_n_i(sel_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe_o(lane_oe_o), .lane_mode_i(mode),
    .quad_enable_bit_i(qe), .lane3_function_select_i(fsel), .tx_dir_i(tx_dir), .tx_byte_i(tx_byte),
    .tx_ready_o(tx_ready_o), .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o),
    .selected_o(selected_o), .standby_o(standby_o), .write_protect_n_o(wp_n_o), .pin_reset_o(pin_reset_o));
  // keep the latest received byte; cut a hang short
  always @(posedge clk_i) begin
    flip <= ~flip;
    cycles <= cycles + 1;
    if (rx_valid_o === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      {last_b, last_f} <= {rx_byte_o, rx_first_o};
    end
    if (tx_ready_o === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
    if (cycles == 12000) begin
      mismatches++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // one byte: rd makes the device send b, else the host sends it
  task automatic io(input logic [7:0] b, input int w, input logic rd);
    logic [7:0] r;
    {tx_byte, tx_dir} = {b, rd};
    host_model_i.xfer(b, w, 8 / w, !rd, r);
    repeat (6) @(negedge clk_i);
    if (rd) begin
      check("read byte", r, b);
      check("lane drive", lane_oe_o, w == 1 ? 4'h2 : 4'((1 << w) - 1));
    end else begin
      check("rx byte", last_b, b);
    end
    tx_dir = 1'b0;
  endtask : io
  task automatic t_idle();
    logic [7:0] r;
    host_model_i.xfer(8'hFF, 1, 8, 1'b1, r);
    check("rx deselected", 8'(rx_cnt), 8'h00);
    check("drive deselected", lane_oe_o, 4'h0);
    check("armed", selected_o, 1'b0);
    $display("test idle done");
  endtask : t_idle
  task automatic t_single();
    host_model_i.sel(1'b0);
    check("selected", {selected_o, standby_o}, 2'h2);
    io(8'hA5, 1, 1'b0);
    io(8'h3C, 1, 1'b0);
    check("first", last_f, 1'b0);
    host_model_i.sel(1'b1);
    check("standby", standby_o, 1'b1);
    host_model_i.sel(1'b0);
    io(8'h81, 1, 1'b0);
    check("first", last_f, 1'b1);
    host_model_i.sel(1'b1);
    $display("test single done");
  endtask : t_single
  // clock idles high from here on
  task automatic t_modes();
    host_model_i.idle_hi = 1'b1;
    host_model_i.sel(1'b1);
    for (int w = 1; w <= 4; w *= 2) begin
      mode = w == 1 ? flash_pins_pkg::lane_single : w == 2 ? flash_pins_pkg::lane_dual : flash_pins_pkg::lane_quad;
      qe = w == 4;
      host_model_i.sel(1'b0);
      io(8'hC3, w, 1'b0);
      if (w == 4) check("protect off", wp_n_o, 1'b1);
      io(8'h69, w, 1'b1);
      host_model_i.sel(1'b1);
    end
    {mode, qe} = {flash_pins_pkg::lane_single, 1'b0};
    $display("test modes done");
  endtask : t_modes
  task automatic t_pause();
    logic [7:0] r1, r2;
    int c;
    c = tx_cnt;
    host_model_i.sel(1'b0);
    {tx_byte, tx_dir} = {8'h96, 1'b1};
    host_model_i.xfer(8'h00, 1, 4, 1'b0, r1);
    host_model_i.pins(1'b0, 1'b0);
    check("paused drive", lane_oe_o[1], 1'b0);
    check("pause role", {pin_reset_o, wp_n_o}, 2'h0);
    host_model_i.pins(1'b1, 1'b1);
    host_model_i.xfer(8'h00, 1, 4, 1'b0, r2);
    check("across pause", {r1[3:0], r2[3:0]}, 8'h96);
    check("ready pulses", 8'(tx_cnt - c), 8'h02);
    tx_dir = 1'b0;
    host_model_i.sel(1'b1);
    $display("test pause done");
  endtask : t_pause
  task automatic t_role();
    logic [7:0] r;
    int c;
    fsel = 1'b1;
    host_model_i.sel(1'b0);
    io(8'h11, 1, 1'b0);
    host_model_i.pins(1'b0, 1'b1);
    check("reset role", pin_reset_o, 1'b1);
    host_model_i.pins(1'b1, 1'b1);
    c = rx_cnt;
    host_model_i.xfer(8'h22, 1, 8, 1'b1, r);
    check("rx after reset", 8'(rx_cnt - c), 8'h00);
    host_model_i.sel(1'b1);
    host_model_i.sel(1'b0);
    io(8'h33, 1, 1'b0);
    host_model_i.sel(1'b1);
    fsel = 1'b0;
    $display("test reset role done");
  endtask : t_role
  // select held low across a reset must not count as the arming fall
  task automatic t_reset();
    logic [7:0] r;
    int c;
    host_model_i.sel(1'b0);
    rst_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    c = rx_cnt;
    host_model_i.xfer(8'h5A, 1, 8, 1'b1, r);
    repeat (6) @(negedge clk_i);
    check("rx without fall", 8'(rx_cnt - c), 8'h00);
    check("armed without fall", selected_o, 1'b0);
    host_model_i.sel(1'b1);
    host_model_i.sel(1'b0);
    io(8'hE7, 1, 1'b0);
    check("first after reset", last_f, 1'b1);
    host_model_i.sel(1'b1);
    $display("test reset done");
  endtask : t_reset
  initial begin
    {rst_n_i, qe, fsel, tx_dir, tx_byte} = 12'h000;
    mode = flash_pins_pkg::lane_single;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_idle();
    t_single();
    t_modes();
    t_pause();
    t_role();
    t_reset();
    results();
  end
endmodule : tb_top
